// File: common/pxh_defs.svh
// constants of the xmii host interface: rates, offsets, fields, resets
`ifndef PXH_DEFS_SVH
`define PXH_DEFS_SVH

`define PXH_PCLK_HZ       100000000
`define PXH_MII_HZ        25000000
`define PXH_RMII_HZ       50000000
`define PXH_MII_DIV       (`PXH_PCLK_HZ / `PXH_MII_HZ)
`define PXH_RMII_DIV      (`PXH_PCLK_HZ / `PXH_RMII_HZ)

`define PXH_BOOT_LATCH    2'h2
`define PXH_BOOT_DONE     2'h3

`define PXH_OFS_CTRL      8'h00
`define PXH_OFS_TXD       8'h04
`define PXH_OFS_STAT      8'h08
`define PXH_OFS_RXD       8'h0c

`define PXH_CTRL_MODE     0
`define PXH_CTRL_INTREV   2
`define PXH_CTRL_SINGLE   3
`define PXH_CTRL_CKSRC    4

`define PXH_STAT_RXAV     0
`define PXH_STAT_TXBUSY   1
`define PXH_STAT_RXDV     2
`define PXH_STAT_OVR      3

`define PXH_MODE_RST      2'h0
`define PXH_CKSRC_RST     2'h0

`endif

// File: common/pxh_if.sv
// xmii pins between the phy end and the mac end, with management
`timescale 1ns/100ps
`default_nettype none
interface pxh_if;
   import pxh_pkg::*;

   logic       txc_p;
   logic       txc_p_oe_n;
   logic       rxc_p;
   logic       rxc_p_oe_n;
   logic       ref_p;
   logic       ref_p_oe_n;
   logic       txc_m;
   logic       txc_m_oe_n;
   logic       rxc_m;
   logic       rxc_m_oe_n;
   logic       ref_m;
   logic       ref_m_oe_n;
   logic       txc;
   logic       rxc;
   logic       ref_clk;
   logic       clk_io;
   logic [3:0] txd;
   logic       tx_en;
   logic [3:0] rxd;
   logic       rx_dv;
   logic       mg_we;
   pxh_cfg_s   mg_cfg;

   // wire level from the enables; an undriven pin reads low
   assign txc     = !txc_p_oe_n ? txc_p : (!txc_m_oe_n & txc_m);
   assign rxc     = !rxc_p_oe_n ? rxc_p : (!rxc_m_oe_n & rxc_m);
   assign ref_clk = !ref_p_oe_n ? ref_p : (!ref_m_oe_n & ref_m);

   modport phy (
      input  txc, rxc, ref_clk, clk_io, txd, tx_en, mg_we, mg_cfg,
      output txc_p, txc_p_oe_n, rxc_p, rxc_p_oe_n, ref_p, ref_p_oe_n,
      output rxd, rx_dv
   );

   modport mac (
      input  txc, rxc, ref_clk, rxd, rx_dv,
      output txc_m, txc_m_oe_n, rxc_m, rxc_m_oe_n, ref_m, ref_m_oe_n,
      output clk_io, txd, tx_en, mg_we, mg_cfg
   );

endinterface
`default_nettype wire

// File: common/pxh_pkg.sv
// types and decode helpers shared by both ends of the xmii link
package pxh_pkg;

   typedef enum logic [1:0] {
      PXH_MII  = 2'h0,
      PXH_RMII = 2'h1,
      PXH_RSV  = 2'h2,
      PXH_REV  = 2'h3
   } pxh_mode_e;

   typedef enum logic [1:0] {
      PXH_CK_XTAL  = 2'h0,
      PXH_CK_REF50 = 2'h1,
      PXH_CK_IN25  = 2'h2,
      PXH_CK_RSV   = 2'h3
   } pxh_cksrc_e;

   typedef struct packed {
      pxh_mode_e  mode;
      logic       int_rev;
      logic       single;
      pxh_cksrc_e cksrc;
   } pxh_cfg_s;

   function automatic logic pxh_is_rmii(input pxh_mode_e m);
      return m == PXH_RMII;
   endfunction

   // index of the last unit in a byte: 2 nibbles or 4 dibits
   function automatic logic [1:0] pxh_last_unit(input pxh_mode_e m);
      return (m == PXH_RMII) ? 2'h3 : 2'h1;
   endfunction

   // the link clock comes from the partner, not the phy's own divider
   function automatic logic pxh_ext_clk(input pxh_cfg_s c);
      return (c.mode == PXH_REV) ||
             ((c.mode == PXH_RMII) && (c.cksrc != PXH_CK_XTAL));
   endfunction

   // a 25 MHz input carries 50 MHz worth of events on both edges
   function automatic logic pxh_both_edges(input pxh_cfg_s c);
      return (c.mode == PXH_RMII) && (c.cksrc == PXH_CK_IN25);
   endfunction

endpackage

// File: logic/pxh_clk_en.sv
// divider making the 25 or 50 MHz link clock level and edge pulses
`timescale 1ns/100ps
`default_nettype none
`include "pxh_defs.svh"
module pxh_clk_en (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic fast,
   output logic      lvl,
   output logic      rise,
   output logic      fall
);
   typedef struct packed {
      logic [1:0] cnt;
      logic       lvl;
      logic       rise;
      logic       fall;
   } pxh_ce_s;

   pxh_ce_s q_r;
   pxh_ce_s q_nxt;

   always_comb begin
      logic [1:0] div;
      div = fast ? 2'(`PXH_RMII_DIV - 1) : 2'(`PXH_MII_DIV - 1);
      q_nxt = q_r;
      q_nxt.cnt = (q_r.cnt >= div) ? 2'h0 : 2'(q_r.cnt + 2'h1);
      // high for the second half of each period
      q_nxt.lvl = fast ? q_nxt.cnt[0] : q_nxt.cnt[1];
      q_nxt.rise = q_nxt.lvl & !q_r.lvl;
      q_nxt.fall = !q_nxt.lvl & q_r.lvl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign lvl  = q_r.lvl;
   assign rise = q_r.rise;
   assign fall = q_r.fall;
endmodule
`default_nettype wire

// File: logic/pxh_mac.sv
// mac end: apb registers, xmii transmit and receive, mode management
`timescale 1ns/100ps
`default_nettype none
`include "pxh_defs.svh"
module pxh_mac (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   pxh_if.mac               xi
);
   import pxh_pkg::*;

   typedef struct packed {
      pxh_cfg_s    cfg;
      logic        mg_we;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [1:0]  pq;
      logic [7:0]  thold;
      logic        thold_v;
      logic [7:0]  tsh;
      logic [1:0]  tcnt;
      logic [3:0]  txd;
      logic        tx_en;
      logic [7:0]  racc;
      logic [1:0]  rcnt;
      logic [7:0]  rbyte;
      logic        ravail;
      logic        rovr;
      logic        clk_oe_n;
      logic        ref_oe_n;
   } pxh_mac_s;

   pxh_mac_s q_r;
   pxh_mac_s q_nxt;

   logic g_lvl;
   logic g_rise;
   logic g_fall;

   // codes 1 and 3 both mean an external 50 MHz reference
   pxh_clk_en u_clk (
      .pclk    (pclk),
      .presetn (presetn),
      .fast    (pxh_is_rmii(q_r.cfg.mode) && q_r.cfg.cksrc[0]),
      .lvl     (g_lvl),
      .rise    (g_rise),
      .fall    (g_fall)
   );

   always_comb begin
      logic        rm;
      logic        e;
      logic        acc;
      logic [1:0]  last;
      logic [31:0] rd;
      logic        ok;
      logic        err;
      rm    = pxh_is_rmii(q_r.cfg.mode);
      last  = pxh_last_unit(q_r.cfg.mode);
      e     = 1'b0;
      acc   = psel && penable;
      rd    = 32'h0;
      ok    = 1'b1;
      err   = 1'b0;
      q_nxt = q_r;
      q_nxt.mg_we   = 1'b0;
      q_nxt.pready  = 1'b0;
      q_nxt.pslverr = 1'b0;
      q_nxt.pq      = {xi.txc, xi.ref_clk};

      // own divider when we source the clock, else the phy's pin edge
      if (pxh_ext_clk(q_r.cfg)) begin
         e = pxh_both_edges(q_r.cfg) ? (g_rise | g_fall) : g_rise;
      end else if (rm) begin
         e = xi.ref_clk & !q_r.pq[0];
      end else begin
         e = xi.txc & !q_r.pq[1];
      end

      // transmit drains first so a completing write's load wins
      if (e) begin
         if (q_r.tcnt != 2'h0) begin
            q_nxt.txd  = rm ? {2'h0, q_r.tsh[1:0]} : q_r.tsh[3:0];
            q_nxt.tsh  = rm ? {2'h0, q_r.tsh[7:2]} : {4'h0, q_r.tsh[7:4]};
            q_nxt.tcnt = 2'(q_r.tcnt - 2'h1);
         end else if (q_r.thold_v) begin
            q_nxt.txd  = rm ? {2'h0, q_r.thold[1:0]} : q_r.thold[3:0];
            q_nxt.tsh  = rm ? {2'h0, q_r.thold[7:2]}
                            : {4'h0, q_r.thold[7:4]};
            q_nxt.tcnt    = last;
            q_nxt.thold_v = 1'b0;
            q_nxt.tx_en   = 1'b1;
         end else begin
            // an empty holding slot ends the frame
            q_nxt.txd   = 4'h0;
            q_nxt.tx_en = 1'b0;
         end
      end

      // apb: answer one cycle into the access phase, tx waits for room
      unique case (paddr)
         `PXH_OFS_CTRL: begin
            rd[`PXH_CTRL_MODE +: 2]  = q_r.cfg.mode;
            rd[`PXH_CTRL_INTREV]     = q_r.cfg.int_rev;
            rd[`PXH_CTRL_SINGLE]     = q_r.cfg.single;
            rd[`PXH_CTRL_CKSRC +: 2] = q_r.cfg.cksrc;
         end
         `PXH_OFS_TXD: begin
            ok = !(pwrite && q_r.thold_v);
         end
         `PXH_OFS_STAT: begin
            rd[`PXH_STAT_RXAV]   = q_r.ravail;
            rd[`PXH_STAT_TXBUSY] = q_r.thold_v | q_r.tx_en;
            rd[`PXH_STAT_RXDV]   = xi.rx_dv;
            rd[`PXH_STAT_OVR]    = q_r.rovr;
         end
         `PXH_OFS_RXD: begin
            rd[7:0] = q_r.rbyte;
         end
         default: begin
            err = 1'b1;
         end
      endcase
      if (acc && !q_r.pready && ok) begin
         q_nxt.pready  = 1'b1;
         q_nxt.pslverr = err;
         q_nxt.prdata  = pwrite ? 32'h0 : rd;
      end
      if (acc && q_r.pready && !q_r.pslverr) begin
         if (pwrite && paddr == `PXH_OFS_CTRL) begin
            q_nxt.cfg.mode    = pxh_mode_e'(pwdata[`PXH_CTRL_MODE +: 2]);
            q_nxt.cfg.int_rev = pwdata[`PXH_CTRL_INTREV];
            q_nxt.cfg.single  = pwdata[`PXH_CTRL_SINGLE];
            q_nxt.cfg.cksrc   = pxh_cksrc_e'(pwdata[`PXH_CTRL_CKSRC +: 2]);
            q_nxt.mg_we       = 1'b1;
         end
         if (pwrite && paddr == `PXH_OFS_TXD) begin
            q_nxt.thold   = pwdata[7:0];
            q_nxt.thold_v = 1'b1;
         end
         if (!pwrite && paddr == `PXH_OFS_RXD) begin
            q_nxt.ravail = 1'b0;
         end
         if (!pwrite && paddr == `PXH_OFS_STAT) begin
            q_nxt.rovr = 1'b0;
         end
      end

      // receive after the clears, so a new byte beats a clear
      if (e) begin
         if (xi.rx_dv) begin
            q_nxt.racc = rm ? {xi.rxd[1:0], q_r.racc[7:2]}
                            : {xi.rxd, q_r.racc[7:4]};
            if (q_r.rcnt == last) begin
               q_nxt.rcnt   = 2'h0;
               q_nxt.rbyte  = q_nxt.racc;
               q_nxt.rovr   = q_nxt.rovr | q_nxt.ravail;
               q_nxt.ravail = 1'b1;
            end else begin
               q_nxt.rcnt = 2'(q_r.rcnt + 2'h1);
            end
         end else begin
            q_nxt.rcnt = 2'h0;
         end
      end

      q_nxt.clk_oe_n = !(q_nxt.cfg.mode == PXH_REV);
      q_nxt.ref_oe_n = !(pxh_is_rmii(q_nxt.cfg.mode) &&
                         q_nxt.cfg.cksrc[0]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r          <= '0;
         q_r.clk_oe_n <= 1'b1;
         q_r.ref_oe_n <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign prdata        = q_r.prdata;
   assign pready        = q_r.pready;
   assign pslverr       = q_r.pslverr;
   assign xi.txc_m      = g_lvl;
   assign xi.rxc_m      = g_lvl;
   assign xi.ref_m      = g_lvl;
   assign xi.clk_io     = g_lvl;
   assign xi.txc_m_oe_n = q_r.clk_oe_n;
   assign xi.rxc_m_oe_n = q_r.clk_oe_n;
   assign xi.ref_m_oe_n = q_r.ref_oe_n;
   assign xi.txd        = q_r.txd;
   assign xi.tx_en      = q_r.tx_en;
   assign xi.mg_we      = q_r.mg_we;
   assign xi.mg_cfg     = q_r.cfg;
endmodule
`default_nettype wire

// File: logic/pxh_phy.sv
// phy end: xmii data path, clocking, strap and management mode select
// How it works
// - mii moves four-bit nibbles each direction
// - phy makes 25 MHz txc and rxc
// - tx_en frames transmit, rx_dv frames receive
// - rmii moves two bits per clock
// - rmii uses one 50 MHz reference clock
// - three rmii clock sources are selectable
// - mode set by strap or management
// - mode code 11 selects reverse mii
// - reverse mode takes txc, rxc as inputs
// - receive outputs feed partner transmit inputs
// - internal reverse joins ports inside, else board
// - second port can be switched off
// - clause 22 style nibble order and management
// - each port carries 100 Mbit/s
// - straps latched after reset before management
// - host controls all but the master strap over management
`timescale 1ns/100ps
`default_nettype none
`include "pxh_defs.svh"
module pxh_phy (
   input  wire logic             pclk,
   input  wire logic             presetn,
   pxh_if.phy                    xi,
   input  wire logic [1:0]       strap_mode,
   input  wire logic             strap_int_rev,
   input  wire logic             strap_single,
   input  wire logic [1:0]       strap_cksrc,
   input  wire logic             strap_master,
   input  wire logic [1:0][7:0]  lrx_byte,
   input  wire logic [1:0]       lrx_stb,
   output logic      [1:0]       lrx_rdy,
   output logic      [1:0][7:0]  ltx_byte,
   output logic      [1:0]       ltx_stb,
   output pxh_pkg::pxh_cfg_s     cfg_o,
   output logic                  role_master,
   output logic                  port_one_on
);
   import pxh_pkg::*;

   typedef struct packed {
      logic [1:0]      boot;
      pxh_cfg_s        cfg;
      logic            master;
      logic [6:0]      st1;
      logic [6:0]      st2;
      logic [2:0]      pin1;
      logic [2:0]      pin2;
      logic [2:0]      pin3;
      logic [7:0]      tacc;
      logic [1:0]      tcnt;
      logic [7:0]      rsh;
      logic [1:0]      rcnt;
      logic [1:0][7:0] hold;
      logic [1:0]      hold_v;
      logic [3:0]      rxd;
      logic            rx_dv;
      logic [1:0][7:0] ltx;
      logic [1:0]      ltx_stb;
      logic [1:0]      rdy;
      logic            clk_oe_n;
      logic            ref_oe_n;
   } pxh_phy_s;

   pxh_phy_s q_r;
   pxh_phy_s q_nxt;

   logic g_lvl;
   logic g_rise;
   logic g_fall;

   // 4 cycles of pclk per mii clock, 2 per rmii clock
   pxh_clk_en u_clk (
      .pclk    (pclk),
      .presetn (presetn),
      .fast    (pxh_is_rmii(q_r.cfg.mode)),
      .lvl     (g_lvl),
      .rise    (g_rise),
      .fall    (g_fall)
   );

   always_comb begin
      logic       rm;
      logic       ext;
      logic       irv;
      logic [1:0] last;
      logic [1:0] k;
      logic       s;
      logic       p;
      logic       samp;
      logic       launch;
      rm     = pxh_is_rmii(q_r.cfg.mode);
      ext    = pxh_ext_clk(q_r.cfg);
      irv    = (q_r.cfg.mode == PXH_REV) && q_r.cfg.int_rev;
      last   = pxh_last_unit(q_r.cfg.mode);
      k      = 2'h0;
      s      = 1'b0;
      p      = 1'b0;
      samp   = 1'b0;
      launch = 1'b0;
      q_nxt  = q_r;
      q_nxt.ltx_stb = '0;

      // pins from the partner pass two flops before use
      q_nxt.pin1 = {xi.txc, xi.ref_clk, xi.clk_io};
      q_nxt.pin2 = q_r.pin1;
      q_nxt.pin3 = q_r.pin2;
      q_nxt.st1  = {strap_mode, strap_int_rev, strap_single,
                    strap_cksrc, strap_master};
      q_nxt.st2  = q_r.st1;

      // straps settle through the synchroniser, then are caught once
      if (q_r.boot != `PXH_BOOT_DONE) begin
         q_nxt.boot = 2'(q_r.boot + 2'h1);
      end
      if (q_r.boot == `PXH_BOOT_LATCH) begin
         q_nxt.cfg.mode    = pxh_mode_e'(q_r.st2[6:5]);
         q_nxt.cfg.int_rev = q_r.st2[4];
         q_nxt.cfg.single  = q_r.st2[3];
         q_nxt.cfg.cksrc   = pxh_cksrc_e'(q_r.st2[2:1]);
         q_nxt.master      = q_r.st2[0];
      end else if (xi.mg_we && q_r.boot == `PXH_BOOT_DONE) begin
         // management overrides the strapped defaults
         q_nxt.cfg = xi.mg_cfg;
      end

      // pick the partner's clock pin: txc in reverse, else rmii source
      if (q_r.cfg.mode == PXH_REV) begin
         k = 2'h2;
      end else if (q_r.cfg.cksrc != PXH_CK_IN25) begin
         k = 2'h1;
      end else begin
         k = 2'h0;
      end
      s = q_r.pin2[k];
      p = q_r.pin3[k];

      // own clock: sample at rise, launch at fall; a partner clock
      // arrives late through the synchroniser, so both act on its edge
      if (ext) begin
         samp   = pxh_both_edges(q_r.cfg) ? (s ^ p) : (s & !p);
         launch = samp;
      end else begin
         samp   = g_rise;
         launch = g_fall;
      end

      // line side bytes are taken only while the holding slot is free
      for (int i = 0; i < 2; i++) begin
         if (lrx_stb[i] && q_r.rdy[i]) begin
            q_nxt.hold[i]   = lrx_byte[i];
            q_nxt.hold_v[i] = 1'b1;
         end
      end

      if (irv) begin
         // ports joined inside: each received byte goes to the other
         for (int i = 0; i < 2; i++) begin
            if (q_r.hold_v[i]) begin
               q_nxt.ltx[1-i]     = q_r.hold[i];
               q_nxt.ltx_stb[1-i] = 1'b1;
               q_nxt.hold_v[i]    = 1'b0;
            end
         end
         q_nxt.rx_dv = 1'b0;
         q_nxt.rxd   = 4'h0;
         q_nxt.tcnt  = 2'h0;
         q_nxt.rcnt  = 2'h0;
      end else begin
         // transmit: units arrive low bits first while tx_en is high
         if (samp) begin
            if (xi.tx_en) begin
               if (rm) begin
                  q_nxt.tacc = {xi.txd[1:0], q_r.tacc[7:2]};
               end else begin
                  q_nxt.tacc = {xi.txd, q_r.tacc[7:4]};
               end
               if (q_r.tcnt == last) begin
                  q_nxt.tcnt       = 2'h0;
                  q_nxt.ltx[0]     = q_nxt.tacc;
                  q_nxt.ltx_stb[0] = 1'b1;
               end else begin
                  q_nxt.tcnt = 2'(q_r.tcnt + 2'h1);
               end
            end else begin
               q_nxt.tcnt = 2'h0;
            end
         end

         // receive: shift the held byte out, rx_dv high meanwhile
         if (launch) begin
            if (q_r.rcnt != 2'h0) begin
               q_nxt.rxd  = rm ? {2'h0, q_r.rsh[1:0]} : q_r.rsh[3:0];
               q_nxt.rsh  = rm ? {2'h0, q_r.rsh[7:2]}
                               : {4'h0, q_r.rsh[7:4]};
               q_nxt.rcnt = 2'(q_r.rcnt - 2'h1);
            end else if (q_r.hold_v[0]) begin
               q_nxt.rxd = rm ? {2'h0, q_r.hold[0][1:0]}
                              : q_r.hold[0][3:0];
               q_nxt.rsh = rm ? {2'h0, q_r.hold[0][7:2]}
                              : {4'h0, q_r.hold[0][7:4]};
               q_nxt.rcnt      = last;
               q_nxt.hold_v[0] = 1'b0;
               q_nxt.rx_dv     = 1'b1;
            end else begin
               q_nxt.rxd   = 4'h0;
               q_nxt.rx_dv = 1'b0;
            end
         end
      end

      // port one in single mode takes nothing; its own pins lie outside
      q_nxt.rdy[0] = !q_nxt.hold_v[0];
      q_nxt.rdy[1] = !q_nxt.hold_v[1] && !q_nxt.cfg.single;
      if (q_nxt.cfg.single) begin
         q_nxt.hold_v[1] = 1'b0;
      end

      // reverse mode releases txc and rxc to the partner
      q_nxt.clk_oe_n = (q_nxt.cfg.mode == PXH_REV);
      q_nxt.ref_oe_n = !(pxh_is_rmii(q_nxt.cfg.mode) &&
                         q_nxt.cfg.cksrc == PXH_CK_XTAL);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r            <= '0;
         q_r.cfg.mode   <= pxh_mode_e'(`PXH_MODE_RST);
         q_r.cfg.cksrc  <= pxh_cksrc_e'(`PXH_CKSRC_RST);
         q_r.clk_oe_n   <= 1'b0;
         q_r.ref_oe_n   <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign xi.txc_p      = g_lvl;
   assign xi.rxc_p      = g_lvl;
   assign xi.ref_p      = g_lvl;
   assign xi.txc_p_oe_n = q_r.clk_oe_n;
   assign xi.rxc_p_oe_n = q_r.clk_oe_n;
   assign xi.ref_p_oe_n = q_r.ref_oe_n;
   assign xi.rxd        = q_r.rxd;
   assign xi.rx_dv      = q_r.rx_dv;
   assign lrx_rdy       = q_r.rdy;
   assign ltx_byte      = q_r.ltx;
   assign ltx_stb       = q_r.ltx_stb;
   assign cfg_o         = q_r.cfg;
   assign role_master   = q_r.master;
   assign port_one_on   = !q_r.cfg.single;
endmodule
`default_nettype wire

// File: testbench/pxh_properties.sv
// concurrent checks on the xmii wires between the phy and mac ends
`timescale 1ns/100ps
`default_nettype none
module pxh_properties (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              txc,
   input wire logic              txc_p_oe_n,
   input wire logic              rxc_p_oe_n,
   input wire logic              ref_p_oe_n,
   input wire logic              ref_clk,
   input wire logic [3:0]        txd,
   input wire logic              tx_en,
   input wire logic [3:0]        rxd,
   input wire logic              rx_dv,
   input wire logic              mg_we,
   input wire pxh_pkg::pxh_cfg_s mg_cfg
);
   import pxh_pkg::*;
   pxh_cfg_s   cfg_r;
   logic [2:0] quiet_r;
   logic       live, mii, rmii, rev;
   // mode checks wait 7 cycles after a write: the clocks change over late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r   <= '0;
         quiet_r <= 3'h0;
      end else if (mg_we) begin
         cfg_r   <= mg_cfg;
         quiet_r <= 3'h1;
      end else if (quiet_r != 3'h0 && quiet_r != 3'h7) begin
         quiet_r <= quiet_r + 3'h1;
      end
   end
   assign live = (quiet_r == 3'h7);
   assign mii  = !cfg_r.mode[0];
   assign rmii = (cfg_r.mode == PXH_RMII);
   assign rev  = (cfg_r.mode == PXH_REV);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !live);
   chk_mii_clk_drive: assert property (
      mii |-> !txc_p_oe_n && !rxc_p_oe_n) else $error("mii clocks undriven");
   chk_mii_clk_rate: assert property (
      mii && $rose(txc) |-> ##1 txc ##1 !txc[*2] ##1 txc)
      else $error("mii clock not 4 cycles");
   chk_rev_clk_input: assert property (
      rev |-> txc_p_oe_n && rxc_p_oe_n) else $error("reverse drives clocks");
   chk_rmii_ref_toggle: assert property (
      rmii && cfg_r.cksrc == PXH_CK_XTAL |-> !ref_p_oe_n &&
      ref_clk != $past(ref_clk)) else $error("ref clock not 50 mhz");
   chk_ext_ref_free: assert property (
      rmii && cfg_r.cksrc == PXH_CK_REF50 |-> ref_p_oe_n)
      else $error("phy fights external ref clock");
   chk_rmii_dibit_width: assert property (
      rmii |-> (!tx_en || txd[3:2] == 2'h0) && (!rx_dv || rxd[3:2] == 2'h0))
      else $error("rmii upper data bits set");
   chk_mii_rxd_hold: assert property (
      mii && rx_dv && $changed(rxd) |=> $stable(rxd)[*3])
      else $error("rxd nibble too short");
   chk_mii_txd_hold: assert property (
      mii && tx_en && $changed(txd) |=> $stable(txd)[*3])
      else $error("txd nibble too short");
   chk_int_rev_idle: assert property (
      rev && cfg_r.int_rev |-> !rx_dv) else $error("pins busy in int reverse");
   chk_mgmt_one_pulse: assert property (
      disable iff (!presetn) mg_we |=> !mg_we) else $error("mg_we too long");
   cover property ($rose(rx_dv));
   cover property (rmii && tx_en);
   cover property (rev && cfg_r.int_rev);
endmodule
`default_nettype wire

// File: testbench/tb.sv
// bench: apb traffic at the mac end, line bytes at the phy end
`timescale 1ns/100ps
`default_nettype none
`include "pxh_defs.svh"
module tb;
   import pxh_pkg::*;
   logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rdat;
   logic            rerr, role_master, port_one_on;
   logic            strap_int_rev, strap_single, strap_master;
   logic [1:0]      strap_mode, strap_cksrc, lrx_stb, lrx_rdy, ltx_stb;
   logic [1:0][7:0] lrx_byte, ltx_byte;
   pxh_cfg_s        cfg_o;
   logic [7:0]      catchq[2][$];
   logic [31:0]     ctl[6] = '{32'h00, 32'h01, 32'h11, 32'h21, 32'h02, 32'h03};
   int              err_count = 0;
   int              num_checks = 0;
   pxh_if xi_if ();
   pxh_phy pxh_phy_inst (.pclk, .presetn, .xi(xi_if), .strap_mode,
      .strap_int_rev, .strap_single, .strap_cksrc, .strap_master, .lrx_byte,
      .lrx_stb, .lrx_rdy, .ltx_byte, .ltx_stb, .cfg_o, .role_master,
      .port_one_on);
   pxh_mac pxh_mac_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .xi(xi_if));
   pxh_properties pxh_properties_inst (.pclk, .presetn, .txc(xi_if.txc),
      .txc_p_oe_n(xi_if.txc_p_oe_n), .rxc_p_oe_n(xi_if.rxc_p_oe_n),
      .ref_p_oe_n(xi_if.ref_p_oe_n), .ref_clk(xi_if.ref_clk),
      .txd(xi_if.txd), .tx_en(xi_if.tx_en), .rxd(xi_if.rxd),
      .rx_dv(xi_if.rx_dv), .mg_we(xi_if.mg_we), .mg_cfg(xi_if.mg_cfg));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // values read right after an edge are the ones that edge sampled
   always @(posedge pclk) begin
      for (int p = 0; p < 2; p++) begin
         if (ltx_stb[p] === 1'b1) catchq[p].push_back(ltx_byte[p]);
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 3000);
      if (n >= 3000) err_count++;
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdat, exp);
   endtask
   task automatic line_in(input int p, input logic [7:0] b);
      int n;
      n = 0;
      while (lrx_rdy[p] !== 1'b1 && n++ < 3000) @(posedge pclk);
      lrx_byte[p] <= b;
      lrx_stb[p]  <= 1'b1;
      @(posedge pclk);
      lrx_stb[p]  <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic catch_byte(input int p, input logic [7:0] b);
      int         n;
      logic [7:0] got;
      n = 0;
      while (catchq[p].size() == 0 && n++ < 3000) @(posedge pclk);
      got = (catchq[p].size() != 0) ? catchq[p].pop_front() : 8'hxx;
      check(32'(got), 32'(b));
   endtask
   task automatic rx_byte(input logic [7:0] b);
      int n;
      n = 0;
      do begin
         apb(1'b0, `PXH_OFS_STAT, 32'h0);
         n++;
      end while (rdat[`PXH_STAT_RXAV] !== 1'b1 && n < 500);
      rd(`PXH_OFS_RXD, 32'(b));
   endtask
   task automatic results();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      results();
   end
   initial begin
      logic [7:0] b;
      {psel, penable, pwrite, paddr, pwdata, lrx_stb, lrx_byte} = '0;
      {strap_int_rev, strap_single, strap_cksrc} = '0;
      strap_mode   = 2'h1;
      strap_master = 1'b1;
      presetn      = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      // a late strap change must leave the latched setup alone
      strap_mode <= 2'h3;
      repeat (4) @(posedge pclk);
      check(32'(cfg_o), 32'h10);
      check(32'(role_master), 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      check(32'(rerr), 32'h1);
      foreach (ctl[i]) begin
         b = 8'h5a + 8'(i);
         apb(1'b1, `PXH_OFS_CTRL, ctl[i]);
         rd(`PXH_OFS_CTRL, ctl[i]);
         check(32'(cfg_o.mode), 32'(ctl[i][1:0]));
         check(32'(cfg_o.cksrc), 32'(ctl[i][5:4]));
         apb(1'b1, `PXH_OFS_TXD, 32'(b));
         apb(1'b1, `PXH_OFS_TXD, 32'(~b));
         catch_byte(0, b);
         catch_byte(0, ~b);
         line_in(0, b ^ 8'h33);
         rx_byte(b ^ 8'h33);
      end
      // two bytes unread: second one sets overrun and stays readable
      line_in(0, 8'h11);
      line_in(0, 8'h22);
      repeat (40) @(posedge pclk);
      rd(`PXH_OFS_STAT, 32'h9);
      rd(`PXH_OFS_RXD, 32'h22);
      rd(`PXH_OFS_STAT, 32'h0);
      apb(1'b1, `PXH_OFS_CTRL, 32'h07);
      line_in(0, 8'h3c);
      catch_byte(1, 8'h3c);
      line_in(1, 8'hc3);
      catch_byte(0, 8'hc3);
      apb(1'b1, `PXH_OFS_CTRL, 32'h08);
      repeat (4) @(posedge pclk);
      check(32'(port_one_on), 32'h0);
      check(32'(lrx_rdy[1]), 32'h0);
      results();
   end
endmodule
`default_nettype wire
